// File: inc/huf_regs.svh
// timing and framing constants of the host serial link
`ifndef HUF_REGS_SVH
`define HUF_REGS_SVH
`define HUF_CLK_PERIOD_NS 4
`define HUF_CLK_HZ (1000000000 / `HUF_CLK_PERIOD_NS)
`define HUF_BAUD_DEF 115200
`define HUF_BAUD_MAX 4000000
`define HUF_BAUD_MIN 56000
`define HUF_FLOWOFF_NS 500000
`define HUF_FLOWOFF_CYC (`HUF_FLOWOFF_NS / `HUF_CLK_PERIOD_NS)
`define HUF_CHAR_BITS 10
`define HUF_LAST_BIT 3'h7
`define HUF_RX_DEPTH 256
`define HUF_ROOM_MARGIN 2
`endif

// File: inc/huf_pkg.sv
// state types shared by both ends of the serial link
package huf_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} huf_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} huf_tx_e;
endpackage

// File: inc/huf_link_if.sv
// the four serial link wires between device and host
`timescale 1ns/1ps
interface huf_link_if;
  logic h2d;
  logic d2h;
  logic rts;
  logic cts;
  modport dev (input h2d, input cts, output d2h, output rts);
  modport host (output h2d, output cts, input d2h, input rts);
endinterface

// File: src/huf_dev.sv
// device end of the host serial link with automatic flow control
//
// What this block does
// - receive on input line, send on output
// - rts low lets host send, high forbids
// - transmit only while cts input low, with flow_auto set; cts ignored otherwise
// - start, eight data, one stop, no parity
// - rates up to 4000 kbps within tolerance
// - start at 115200 bps after reset
// - command reprograms rate, 56 to 4000 kbps
// - data moves by stream transfers to memory
// - automatic flow control with software override
// - keep receiving 500 us after rts rises
// - link pins on defaults during, after reset
// - other host interface detected releases pins
`timescale 1ns/1ps
`include "huf_regs.svh"
module huf_dev #(
  parameter int CLK_HZ = `HUF_CLK_HZ,
  parameter int BAUD_DEF = `HUF_BAUD_DEF,
  parameter int RX_DEPTH = `HUF_RX_DEPTH,
  parameter int FLOWOFF_CYC = `HUF_FLOWOFF_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link pins
  huf_link_if.dev link,
  // pin sharing
  input wire logic other_if_det,
  input wire logic [1:0] alt_out,
  // rate command
  input wire logic baud_set,
  input wire logic [15:0] baud_div,
  output logic baud_err,
  // flow control setting
  input wire logic flow_auto,
  input wire logic rts_manual,
  // transmit stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // receive stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  output logic rx_overrun
);
  // ----------------------------------------------------------------
  // constants and state
  // ----------------------------------------------------------------
  localparam int AW = $clog2(RX_DEPTH);
  localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / BAUD_DEF);
  localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / `HUF_BAUD_MAX);
  localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / `HUF_BAUD_MIN);
  localparam logic [AW:0] DEPTH = (AW + 1)'(RX_DEPTH);

  typedef struct packed {
    huf_pkg::huf_rx_e rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_prev;
    huf_pkg::huf_tx_e tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_full;
    logic tx_line;
    logic txr;
    logic [15:0] div;
    logic [AW:0] room;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] used;
    logic out_v;
    logic [7:0] out_d;
    logic ovr;
    logic berr;
    logic pin_txd;
    logic pin_rts;
  } huf_dev_s;

  huf_dev_s s_r;
  huf_dev_s s_nxt;
  logic [7:0] mem [RX_DEPTH];
  logic we;
  logic active;
  logic line;
  logic [AW:0] free;

  // characters that can still land in the flow-off time, plus margin
  function automatic logic [AW:0] headroom(input logic [15:0] div);
    int h;
    h = FLOWOFF_CYC / (int'(div) * `HUF_CHAR_BITS) + `HUF_ROOM_MARGIN;
    headroom = (AW + 1)'(h);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    we = 1'b0;
    active = !other_if_det;
    line = active ? link.h2d : 1'b1;
    s_nxt.ovr = 1'b0;
    s_nxt.berr = 1'b0;

    // rate command, refused outside the supported range
    if (baud_set) begin
      if (baud_div >= DIV_MIN && baud_div <= DIV_MAX) begin
        s_nxt.div = baud_div;
        s_nxt.room = headroom(baud_div);
      end else begin
        s_nxt.berr = 1'b1;
      end
    end

    // receiver, taking characters even with rts high, except while other_if_det releases the pins
    s_nxt.rx_prev = line;
    unique case (s_r.rx_st)
      huf_pkg::RX_IDLE: begin
        if (s_r.rx_prev && !line) begin
          s_nxt.rx_st = huf_pkg::RX_START;
          s_nxt.rx_cnt = s_r.div >> 1;
        end
      end
      huf_pkg::RX_START: begin
        if (s_r.rx_cnt == 16'h0000) begin
          s_nxt.rx_st = line ? huf_pkg::RX_IDLE : huf_pkg::RX_DATA;
          s_nxt.rx_cnt = s_r.div - 16'h0001;
          s_nxt.rx_bit = 3'h0;
        end else begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end
      end
      huf_pkg::RX_DATA: begin
        if (s_r.rx_cnt == 16'h0000) begin
          s_nxt.rx_sh = {line, s_r.rx_sh[7:1]};
          s_nxt.rx_cnt = s_r.div - 16'h0001;
          s_nxt.rx_bit = s_r.rx_bit + 3'h1;
          if (s_r.rx_bit == `HUF_LAST_BIT) begin
            s_nxt.rx_st = huf_pkg::RX_STOP;
          end
        end else begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end
      end
      huf_pkg::RX_STOP: begin
        if (s_r.rx_cnt == 16'h0000) begin
          s_nxt.rx_st = huf_pkg::RX_IDLE;
          if (line) begin
            if (s_r.used == DEPTH) begin
              s_nxt.ovr = 1'b1;
            end else begin
              we = 1'b1;
            end
          end
        end else begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end
      end
    endcase

    // receive stream stage fed from the buffer
    if (s_r.out_v && rx_ready) begin
      s_nxt.out_v = 1'b0;
    end
    if (!s_nxt.out_v && s_r.used != '0) begin
      s_nxt.out_v = 1'b1;
      s_nxt.out_d = mem[s_r.rp];
      s_nxt.rp = s_r.rp + AW'(1);
      s_nxt.used = s_r.used - (AW + 1)'(1);
    end
    if (we) begin
      s_nxt.wp = s_r.wp + AW'(1);
      s_nxt.used = s_nxt.used + (AW + 1)'(1);
    end

    // flow control toward the host
    free = DEPTH - s_nxt.used;
    if (!active) begin
      s_nxt.pin_rts = alt_out[1];
    end else if (flow_auto) begin
      s_nxt.pin_rts = (free <= s_r.room);
    end else begin
      s_nxt.pin_rts = rts_manual;
    end

    // transmitter
    if (tx_valid && s_r.txr) begin
      s_nxt.tx_full = 1'b1;
      s_nxt.tx_sh = tx_data;
    end
    unique case (s_r.tx_st)
      huf_pkg::TX_IDLE: begin
        s_nxt.tx_line = 1'b1;
        if (s_r.tx_full && active && (!flow_auto || !link.cts)) begin
          s_nxt.tx_st = huf_pkg::TX_START;
          s_nxt.tx_cnt = s_r.div - 16'h0001;
          s_nxt.tx_line = 1'b0;
        end
      end
      huf_pkg::TX_START: begin
        if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_st = huf_pkg::TX_DATA;
          s_nxt.tx_cnt = s_r.div - 16'h0001;
          s_nxt.tx_bit = 3'h0;
          s_nxt.tx_line = s_r.tx_sh[0];
        end else begin
          s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
        end
      end
      huf_pkg::TX_DATA: begin
        if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_cnt = s_r.div - 16'h0001;
          s_nxt.tx_bit = s_r.tx_bit + 3'h1;
          s_nxt.tx_sh = s_r.tx_sh >> 1;
          s_nxt.tx_line = s_r.tx_sh[1];
          if (s_r.tx_bit == `HUF_LAST_BIT) begin
            s_nxt.tx_st = huf_pkg::TX_STOP;
            s_nxt.tx_line = 1'b1;
          end
        end else begin
          s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
        end
      end
      huf_pkg::TX_STOP: begin
        if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_st = huf_pkg::TX_IDLE;
          s_nxt.tx_full = 1'b0;
        end else begin
          s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
        end
      end
    endcase
    s_nxt.txr = !s_nxt.tx_full;
    s_nxt.pin_txd = active ? s_nxt.tx_line : alt_out[0];
  end

  // ----------------------------------------------------------------
  // registers and receive buffer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.div <= DIV_DEF;
      s_r.room <= headroom(DIV_DEF);
      s_r.rx_prev <= 1'b1;
      s_r.tx_line <= 1'b1;
      s_r.txr <= 1'b1;
      s_r.pin_txd <= 1'b1;
      s_r.pin_rts <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
    if (we) begin
      mem[s_r.wp] <= s_r.rx_sh;
    end
  end

  // outputs straight from the state register
  assign link.d2h = s_r.pin_txd;
  assign link.rts = s_r.pin_rts;
  assign baud_err = s_r.berr;
  assign tx_ready = s_r.txr;
  assign rx_valid = s_r.out_v;
  assign rx_data = s_r.out_d;
  assign rx_overrun = s_r.ovr;
endmodule

// File: src/huf_host.sv
// host end of the serial link honouring device flow control
`timescale 1ns/1ps
`include "huf_regs.svh"
module huf_host #(
  parameter int CLK_HZ = `HUF_CLK_HZ,
  parameter int BAUD_DEF = `HUF_BAUD_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link pins
  huf_link_if.host link,
  // rate command
  input wire logic baud_set,
  input wire logic [15:0] baud_div,
  // flow control
  input wire logic accept,
  // transmit stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // receive strobe
  output logic rx_valid,
  output logic [7:0] rx_data
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / BAUD_DEF);

  typedef struct packed {
    huf_pkg::huf_rx_e rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_prev;
    huf_pkg::huf_tx_e tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [9:0] tx_sh;
    logic txr;
    logic [15:0] div;
    logic rxv;
    logic [7:0] rxd;
    logic txd;
    logic cts;
  } huf_host_s;

  huf_host_s s_r;
  huf_host_s s_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rxv = 1'b0;
    if (baud_set) begin
      s_nxt.div = baud_div;
    end
    s_nxt.cts = !accept;

    // receiver
    s_nxt.rx_prev = link.d2h;
    unique case (s_r.rx_st)
      huf_pkg::RX_IDLE: begin
        if (s_r.rx_prev && !link.d2h) begin
          s_nxt.rx_st = huf_pkg::RX_START;
          s_nxt.rx_cnt = s_r.div >> 1;
        end
      end
      huf_pkg::RX_START: begin
        if (s_r.rx_cnt == 16'h0000) begin
          s_nxt.rx_st = link.d2h ? huf_pkg::RX_IDLE : huf_pkg::RX_DATA;
          s_nxt.rx_cnt = s_r.div - 16'h0001;
          s_nxt.rx_bit = 3'h0;
        end else begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end
      end
      huf_pkg::RX_DATA: begin
        if (s_r.rx_cnt == 16'h0000) begin
          s_nxt.rx_sh = {link.d2h, s_r.rx_sh[7:1]};
          s_nxt.rx_cnt = s_r.div - 16'h0001;
          s_nxt.rx_bit = s_r.rx_bit + 3'h1;
          if (s_r.rx_bit == `HUF_LAST_BIT) begin
            s_nxt.rx_st = huf_pkg::RX_STOP;
          end
        end else begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end
      end
      huf_pkg::RX_STOP: begin
        if (s_r.rx_cnt == 16'h0000) begin
          s_nxt.rx_st = huf_pkg::RX_IDLE;
          s_nxt.rxv = link.d2h;
          s_nxt.rxd = s_r.rx_sh;
        end else begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end
      end
    endcase

    // transmitter, one whole frame shifted from a ten-bit register
    unique case (s_r.tx_st)
      huf_pkg::TX_IDLE: begin
        s_nxt.txd = 1'b1;
        if (tx_valid && s_r.txr && !link.rts) begin
          s_nxt.tx_st = huf_pkg::TX_START;
          s_nxt.tx_sh = {1'b1, tx_data, 1'b0};
          s_nxt.tx_cnt = s_r.div - 16'h0001;
          s_nxt.tx_bit = 3'h0;
          s_nxt.txd = 1'b0;
          s_nxt.txr = 1'b0;
        end
      end
      // start bit for a full bit time, then the first data bit
      huf_pkg::TX_START: begin
        if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_st = huf_pkg::TX_DATA;
          s_nxt.tx_cnt = s_r.div - 16'h0001;
          s_nxt.tx_bit = 3'h0;
          s_nxt.tx_sh = s_r.tx_sh >> 1;
          s_nxt.txd = s_r.tx_sh[1];
        end else begin
          s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
        end
      end
      huf_pkg::TX_DATA: begin
        if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_cnt = s_r.div - 16'h0001;
          s_nxt.tx_sh = s_r.tx_sh >> 1;
          s_nxt.txd = s_r.tx_sh[1];
          s_nxt.tx_bit = s_r.tx_bit + 3'h1;
          if (s_r.tx_bit == `HUF_LAST_BIT) begin
            s_nxt.tx_st = huf_pkg::TX_STOP;
          end
        end else begin
          s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
        end
      end
      // stop bit held high a full bit time before the next start
      huf_pkg::TX_STOP: begin
        if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_st = huf_pkg::TX_IDLE;
          s_nxt.txr = 1'b1;
        end else begin
          s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.div <= DIV_DEF;
      s_r.rx_prev <= 1'b1;
      s_r.txd <= 1'b1;
      s_r.txr <= 1'b1;
      s_r.cts <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign link.h2d = s_r.txd;
  assign link.cts = s_r.cts;
  assign tx_ready = s_r.txr;
  assign rx_valid = s_r.rxv;
  assign rx_data = s_r.rxd;
endmodule

// File: test/huf_link_props.sv
// link-level checks on the four wires between the device and host ends
`timescale 1ns/1ps
module huf_link_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link wires
  input wire logic h2d,
  input wire logic d2h,
  input wire logic rts,
  input wire logic cts
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [9:0] h_wait_r;
  logic [9:0] d_wait_r;
  // idle cycles while the far side says stop, saturating
  always_ff @(posedge mclk) begin
    if (!rst_n || !h2d || !rts) h_wait_r <= 10'h000;
    else if (h_wait_r != 10'h3ff) h_wait_r <= h_wait_r + 10'h001;
    if (!rst_n || !d2h || !cts) d_wait_r <= 10'h000;
    else if (d_wait_r != 10'h3ff) d_wait_r <= d_wait_r + 10'h001;
  end
  // a start bit lasts at least eight clock cycles
  sequence h_low8;
    !h2d [*8];
  endsequence
  sequence d_low8;
    !d2h [*8];
  endsequence
  AST_HOST_RESET: assert property ($rose(rst_n) |-> h2d && cts) else $error("host end not idle after reset");
  AST_DEV_RESET: assert property ($rose(rst_n) |-> d2h && !rts) else $error("device end not idle after reset");
  AST_H2D_START: assert property ($fell(h2d) |-> h_low8) else $error("short start bit toward device");
  AST_D2H_START: assert property ($fell(d2h) |-> d_low8) else $error("short start bit toward host");
  AST_H2D_BIT_MIN: assert property ($rose(h2d) |-> !$past(h2d, 8)) else $error("low bit too short");
  AST_D2H_BIT_MIN: assert property ($rose(d2h) |-> !$past(d2h, 8)) else $error("low bit too short");
  AST_HOST_WAITS_RTS: assert property ((h_wait_r >= 10'h258) && rts |=> h2d) else $error("host sent while stopped");
  AST_DEV_WAITS_CTS: assert property ((d_wait_r >= 10'h258) && cts |=> d2h) else $error("device sent while held");
endmodule

// File: test/host_uart_flow_ctrl_tb.sv
// self-checking bench joining the device and host ends over one link
`timescale 1ns/1ps
`include "huf_regs.svh"
module host_uart_flow_ctrl_tb;
  localparam int FLOW_CYC = 2000;
  localparam int DEPTH = 16;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic other_if_det = 1'b0;
  logic [1:0] alt_out = 2'h0;
  logic d_bset = 1'b0;
  logic h_bset = 1'b0;
  logic [15:0] bdiv = 16'h0000;
  logic flow_auto = 1'b1;
  logic rts_manual = 1'b0;
  logic accept = 1'b0;
  logic rx_ready = 1'b1;
  logic d_tv = 1'b0;
  logic h_tv = 1'b0;
  logic [7:0] d_td = 8'h00;
  logic [7:0] h_td = 8'h00;
  logic baud_err, d_tr, d_rv, rx_overrun, h_tr, h_rv;
  logic [7:0] d_rd, h_rd;
  logic [7:0] to_dev[$], to_host[$], at_dev[$], at_host[$];
  int error_cnt = 0;
  int samples_checked = 0;
  int ovr_cnt = 0;
  int berr_cnt = 0;
  int b0;
  int divs[5];
  huf_link_if lnk();
  huf_dev #(.RX_DEPTH(DEPTH), .FLOWOFF_CYC(FLOW_CYC)) u_huf_dev (.mclk(mclk), .rst_n(rst_n), .link(lnk),
    .other_if_det(other_if_det), .alt_out(alt_out), .baud_set(d_bset), .baud_div(bdiv), .baud_err(baud_err),
    .flow_auto(flow_auto), .rts_manual(rts_manual), .tx_valid(d_tv), .tx_data(d_td), .tx_ready(d_tr),
    .rx_valid(d_rv), .rx_data(d_rd), .rx_ready(rx_ready), .rx_overrun(rx_overrun));
  huf_host u_huf_host (.mclk(mclk), .rst_n(rst_n), .link(lnk), .baud_set(h_bset), .baud_div(bdiv),
    .accept(accept), .tx_valid(h_tv), .tx_data(h_td), .tx_ready(h_tr), .rx_valid(h_rv), .rx_data(h_rd));
  huf_link_props u_huf_link_props (.mclk(mclk), .rst_n(rst_n), .h2d(lnk.h2d), .d2h(lnk.d2h), .rts(lnk.rts),
    .cts(lnk.cts));
  // 250 MHz clock
  always #2 mclk = ~mclk;
  // capture delivered bytes and one-cycle pulses
  always @(posedge mclk) begin
    if (h_rv === 1'b1) at_host.push_back(h_rd);
    if (d_rv === 1'b1 && rx_ready === 1'b1) at_dev.push_back(d_rd);
    if (rx_overrun === 1'b1) ovr_cnt++;
    if (baud_err === 1'b1) berr_cnt++;
  end
  // expectation helpers
  function automatic int bit_cyc(input int baud);
    return `HUF_CLK_HZ / baud;
  endfunction
  function automatic logic exp_err(input int d);
    return d < bit_cyc(`HUF_BAUD_MAX) || d > bit_cyc(`HUF_BAUD_MIN);
  endfunction
  function automatic int exp_room(input int d);
    return FLOW_CYC / (d * 10) + 2;
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // push n bytes through one end, valid held up between bytes
  task automatic send(input bit from_host, input int n, input logic [7:0] first);
    logic [7:0] b;
    int w;
    for (int i = 0; i < n; i++) begin
      b = (i == 0) ? first : 8'($urandom());
      if (from_host) begin
        h_tv <= 1'b1;
        h_td <= b;
        to_dev.push_back(b);
      end else begin
        d_tv <= 1'b1;
        d_td <= b;
        to_host.push_back(b);
      end
      w = 0;
      do begin
        @(posedge mclk);
        w++;
      end while (w < 40000 && !(from_host ? (h_tr === 1'b1 && lnk.rts === 1'b0) : d_tr === 1'b1));
      if (w >= 40000) chk("send_wait", 16'h0001, 16'h0000);
    end
    if (from_host) h_tv <= 1'b0;
    else d_tv <= 1'b0;
  endtask
  // wait for delivery, then compare in order
  task automatic expect_rx(input bit dev_end);
    int w;
    logic [7:0] g;
    w = 0;
    while (w < 30000 && (dev_end ? at_dev.size() < to_dev.size() : at_host.size() < to_host.size())) begin
      @(posedge mclk);
      w++;
    end
    if (dev_end) begin
      chk("dev_rx_count", 16'(at_dev.size()), 16'(to_dev.size()));
      while (at_dev.size() > 0 && to_dev.size() > 0) begin
        g = at_dev.pop_front();
        chk("dev_rx_byte", {8'h00, g}, {8'h00, to_dev.pop_front()});
      end
    end else begin
      chk("host_rx_count", 16'(at_host.size()), 16'(to_host.size()));
      while (at_host.size() > 0 && to_host.size() > 0) begin
        g = at_host.pop_front();
        chk("host_rx_byte", {8'h00, g}, {8'h00, to_host.pop_front()});
      end
    end
  endtask
  // low time of a device start bit
  task automatic start_len(input int exp);
    int n;
    n = 0;
    while (lnk.d2h !== 1'b0 && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (lnk.d2h === 1'b0 && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    chk("bit_time", 16'(n), 16'(exp));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    cyc(90000);
    error_cnt++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    void'($urandom(91811));
    divs = '{61, 4465, 4464, $urandom_range(4464, 62), 62};
    cyc(10);
    rst_n <= 1'b1;
    accept <= 1'b1;
    cyc(4);
    // default rate, both directions
    fork
      send(0, 1, 8'ha5);
      send(1, 1, 8'h3c);
      start_len(bit_cyc(`HUF_BAUD_DEF));
    join
    expect_rx(0);
    expect_rx(1);
    // rate commands, refused and accepted
    foreach (divs[i]) begin
      bdiv <= 16'(divs[i]);
      d_bset <= 1'b1;
      h_bset <= 1'b1;
      b0 = berr_cnt;
      @(posedge mclk);
      d_bset <= 1'b0;
      h_bset <= 1'b0;
      cyc(3);
      chk("baud_err", 16'(berr_cnt - b0), {15'h0000, exp_err(divs[i])});
    end
    fork
      send(0, 1, 8'h01);
      start_len(62);
    join
    expect_rx(0);
    fork
      send(0, 6, 8'($urandom()));
      send(1, 6, 8'hff);
    join
    expect_rx(0);
    expect_rx(1);
    // host holds device transmit off
    accept <= 1'b0;
    cyc(3);
    send(0, 1, 8'h5a);
    cyc(800);
    chk("held_line", {15'h0000, lnk.d2h}, 16'h0001);
    chk("held_count", 16'(at_host.size()), 16'h0000);
    accept <= 1'b1;
    expect_rx(0);
    // device buffer fills, rts stops the host; first byte waits in the output stage
    rx_ready <= 1'b0;
    send(1, DEPTH - exp_room(62), 8'h00);
    cyc(700);
    chk("rts_below", {15'h0000, lnk.rts}, 16'h0000);
    send(1, 1, 8'h80);
    cyc(700);
    chk("rts_full", {15'h0000, lnk.rts}, 16'h0001);
    fork
      send(1, 3, 8'h7e);
    join_none
    cyc(1400);
    chk("stopped", {14'h0000, lnk.rts, lnk.h2d}, 16'h0003);
    rx_ready <= 1'b1;
    wait fork;
    expect_rx(1);
    // software override and overrun
    flow_auto <= 1'b0;
    rts_manual <= 1'b1;
    cyc(3);
    chk("rts_manual_hi", {15'h0000, lnk.rts}, 16'h0001);
    rts_manual <= 1'b0;
    rx_ready <= 1'b0;
    cyc(3);
    chk("rts_manual_lo", {15'h0000, lnk.rts}, 16'h0000);
    b0 = ovr_cnt;
    send(1, DEPTH + 3, 8'h11);
    cyc(700);
    chk("overrun", {15'h0000, ovr_cnt > b0}, 16'h0001);
    rx_ready <= 1'b1;
    cyc(100);
    to_dev.delete();
    at_dev.delete();
    flow_auto <= 1'b1;
    // pins handed to another function
    other_if_det <= 1'b1;
    alt_out <= 2'h2;
    cyc(100);
    chk("alt_a", {14'h0000, lnk.rts, lnk.d2h}, 16'h0002);
    alt_out <= 2'h1;
    cyc(3);
    chk("alt_b", {14'h0000, lnk.rts, lnk.d2h}, 16'h0001);
    other_if_det <= 1'b0;
    alt_out <= 2'h0;
    cyc(1400);
    chk("pins_back", {14'h0000, lnk.rts, lnk.d2h}, 16'h0001);
    at_host.delete();
    tally_and_finish();
  end
endmodule
